// ---- design/spi_pkg.sv ----
package spi_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL1_OFF  = 8'h00;
  localparam logic [7:0] CTRL2_OFF  = 8'h04;
  localparam logic [7:0] BAUD_OFF   = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] DATA_OFF   = 8'h10;

  // Control register one fields
  localparam int UNIT_ENABLE_BIT     = 0;
  localparam int CONTROLLER_ROLE_BIT = 1;
  localparam int SELECT_OUT_EN_BIT   = 2;

  // Control register two fields
  localparam int SINGLE_PIN_BIT   = 0;
  localparam int SHARED_OE_BIT    = 1;
  localparam int HALT_IN_WAIT_BIT = 2;
  localparam int FAULT_DETECT_BIT = 3;

  // Baud register fields
  localparam int BAUD_SELECT_LSB    = 0;
  localparam int BAUD_PRESELECT_LSB = 4;

  // Status register fields
  localparam int DONE_BIT     = 0;
  localparam int TX_EMPTY_BIT = 1;
  localparam int FAULT_BIT    = 2;
  localparam int BUSY_BIT     = 3;

  // Reset values
  localparam logic [2:0] CTRL1_RESET = 3'h0;
  localparam logic [3:0] CTRL2_RESET = 4'h0;
  localparam logic [2:0] BAUD_FIELD_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET  = 8'h00;

  // Transfer geometry: eight bits, two clock edges each
  localparam logic [4:0] LAST_EDGE = 5'h0F;
  localparam logic [2:0] LAST_BIT  = 3'h7;

  // One group of serial pins
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic sel;
  } spi_pins_s;

endpackage

// ---- design/spi_baud_fault_lowpower.sv ----
// Behaviour
// - Serial clock divisor is (baud_preselect+1) times 2 to the (baud_select+1).
// - Both fields zero divide by 2; select 001 gives 4, 010 gives 8.
// - Preselect 001 doubles, 010 triples the select divisor.
// - Divider runs only as controller during a transfer.
// - Automatic select drives pin low during transfer, high while idle.
// - Automatic select needs controller, select_output_enable, fault_detect_enable; disables fault detection.
// - Single-pin mode uses MOSI as controller, MISO as target.
// - shared_pin_output_enable sets shared pin direction; pin always feeds shift input.
// - Clock is output as controller, input as target; select is target input.
// - Select low as controller with fault detection sets fault_flag.
// - No fault without fault_detect_enable, and never as target.
// - Fault disables drivers, aborts transfer, loses partial byte.
// - Fault in single-pin controller mode clears shared_pin_output_enable.
// - Status read with fault set, then control one write, clears fault_flag.
// - Unit disabled stops core; registers stay accessible.
// - Halt in wait as controller pauses transfer, resumes on exit.
// - Target keeps shifting in wait while external clock runs.
// - Target defers done flag and data copy until stop exit, or wait exit with halt_in_wait.
// - Target discards byte in progress on stop entry, or wait entry with halt_in_wait.
// - Stop freezes controller transfer; target stays synchronised; ignores halt_in_wait.
// - Data register reads zero after reset until data arrives.
// - Target without data write sends previous shift contents.
// - Fault clears controller_role.
// - Interrupt is OR of fault, done and transmit-empty, only while enabled.
`timescale 1ns/10ps

module spi_baud_fault_lowpower (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Power state of the system
  input  wire logic               waitMode,
  input  wire logic               stopMode,
  // Serial pins
  input  wire spi_pkg::spi_pins_s pinIn,
  output spi_pkg::spi_pins_s      pinOut,
  output spi_pkg::spi_pins_s      pinOe,
  // Request to the interrupt controller
  output logic                    irq
);

  function automatic logic [10:0] halfLen(input logic [2:0] pre, input logic [2:0] sel);
    halfLen = 11'({8'h00, pre} + 11'h001) << sel;
  endfunction

  function automatic logic isOff(input logic [7:0] a, input logic [7:0] off);
    isOff = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic        unitEnable, controllerRole, selectOutEn;
  logic        singlePin, sharedOe, haltInWait, faultDetectEn;
  logic [2:0]  baudSelect, baudPreselect;
  logic        faultFlag, faultArmed, doneFlag, doneArmed, txEmpty;
  logic [7:0]  txData, rxData, shift;
  logic        rxBit, busy, pendingCopy, discardNext;
  logic [4:0]  edgeCnt;
  logic [2:0]  bitCnt;
  logic [10:0] halfCnt;
  logic        sclkReg;
  logic [1:0]  sclkSync, selSync, mosiSync, misoSync;
  logic        sclkLast, selLast, frozenLast;

  logic setupPh, accessPh, wrAcc, rdAcc, mapped;
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign wrAcc    = accessPh & pwrite;
  assign rdAcc    = accessPh & ~pwrite;
  assign mapped   = isOff(paddr, spi_pkg::CTRL1_OFF) | isOff(paddr, spi_pkg::CTRL2_OFF) |
                    isOff(paddr, spi_pkg::BAUD_OFF) | isOff(paddr, spi_pkg::STATUS_OFF) |
                    isOff(paddr, spi_pkg::DATA_OFF);
  assign pready   = accessPh;
  assign pslverr  = accessPh & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (rst) begin
      sclkSync <= 2'h0;
      selSync  <= 2'h3;
      mosiSync <= 2'h0;
      misoSync <= 2'h0;
      sclkLast <= 1'b0;
      selLast  <= 1'b1;
    end else begin
      sclkSync <= {sclkSync[0], pinIn.sclk};
      selSync  <= {selSync[0], pinIn.sel};
      mosiSync <= {mosiSync[0], pinIn.mosi};
      misoSync <= {misoSync[0], pinIn.miso};
      sclkLast <= sclkSync[1];
      selLast  <= selSync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic frozen, freezeEntry, freezeExit, autoSelect, faultEvt;
  logic tgtActive, tgtSelStart, tgtRise, tgtFall, tgtComplete;
  logic ctlStart, ctlTick, ctlComplete, serIn;

  assign frozen      = stopMode | (waitMode & haltInWait);
  assign freezeEntry = frozen & ~frozenLast;
  assign freezeExit  = ~frozen & frozenLast;
  assign autoSelect  = controllerRole & selectOutEn & faultDetectEn;
  assign faultEvt    = unitEnable & controllerRole & faultDetectEn & ~selectOutEn &
                       ~selSync[1];

  // Shift input: shared pin in single-pin mode, else the opposite data pin
  always_comb begin
    if (controllerRole) begin
      serIn = singlePin ? mosiSync[1] : misoSync[1];
    end else begin
      serIn = singlePin ? misoSync[1] : mosiSync[1];
    end
  end

  assign tgtActive   = unitEnable & ~controllerRole & ~faultFlag & ~selSync[1];
  assign tgtSelStart = tgtActive & selLast;
  assign tgtRise     = tgtActive & sclkSync[1] & ~sclkLast;
  assign tgtFall     = tgtActive & ~sclkSync[1] & sclkLast;
  assign tgtComplete = tgtFall & (bitCnt == spi_pkg::LAST_BIT);

  assign ctlStart    = unitEnable & controllerRole & ~busy & ~txEmpty & ~faultFlag & ~frozen & ~faultEvt;
  assign ctlTick     = busy & ~frozen &
                       (halfCnt == halfLen(baudPreselect, baudSelect) - 11'h001);
  assign ctlComplete = ctlTick & (edgeCnt == spi_pkg::LAST_EDGE);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and fault handling
  always_ff @(posedge clk) begin
    if (rst) begin
      {selectOutEn, controllerRole, unitEnable} <= spi_pkg::CTRL1_RESET;
      {faultDetectEn, haltInWait, sharedOe, singlePin} <= spi_pkg::CTRL2_RESET;
      baudSelect    <= spi_pkg::BAUD_FIELD_RESET;
      baudPreselect <= spi_pkg::BAUD_FIELD_RESET;
      faultFlag     <= 1'b0;
      faultArmed    <= 1'b0;
    end else begin
      if (wrAcc && isOff(paddr, spi_pkg::CTRL1_OFF)) begin
        unitEnable     <= pwdata[spi_pkg::UNIT_ENABLE_BIT];
        controllerRole <= pwdata[spi_pkg::CONTROLLER_ROLE_BIT];
        selectOutEn    <= pwdata[spi_pkg::SELECT_OUT_EN_BIT];
      end
      if (wrAcc && isOff(paddr, spi_pkg::CTRL2_OFF)) begin
        singlePin     <= pwdata[spi_pkg::SINGLE_PIN_BIT];
        sharedOe      <= pwdata[spi_pkg::SHARED_OE_BIT];
        haltInWait    <= pwdata[spi_pkg::HALT_IN_WAIT_BIT];
        faultDetectEn <= pwdata[spi_pkg::FAULT_DETECT_BIT];
      end
      if (wrAcc && isOff(paddr, spi_pkg::BAUD_OFF)) begin
        baudSelect    <= pwdata[spi_pkg::BAUD_SELECT_LSB +: 3];
        baudPreselect <= pwdata[spi_pkg::BAUD_PRESELECT_LSB +: 3];
      end
      if (rdAcc && isOff(paddr, spi_pkg::STATUS_OFF) && faultFlag) begin
        faultArmed <= 1'b1;
      end
      if (wrAcc && isOff(paddr, spi_pkg::CTRL1_OFF) && faultArmed) begin
        faultFlag  <= 1'b0;
        faultArmed <= 1'b0;
      end
      if (faultEvt) begin
        faultFlag      <= 1'b1;
        faultArmed     <= 1'b0;
        controllerRole <= 1'b0;
        if (singlePin) begin
          sharedOe <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller baud divider and clock generation
  always_ff @(posedge clk) begin
    if (rst) begin
      busy    <= 1'b0;
      halfCnt <= 11'h000;
      edgeCnt <= 5'h00;
      sclkReg <= 1'b0;
    end else if (!unitEnable || faultEvt || !controllerRole) begin
      busy    <= 1'b0;
      halfCnt <= 11'h000;
      edgeCnt <= 5'h00;
      sclkReg <= 1'b0;
    end else if (ctlStart) begin
      busy    <= 1'b1;
      halfCnt <= 11'h000;
      edgeCnt <= 5'h00;
      sclkReg <= 1'b0;
    end else if (busy && !frozen) begin
      if (ctlTick) begin
        halfCnt <= 11'h000;
        edgeCnt <= edgeCnt + 5'h01;
        sclkReg <= ~sclkReg;
        if (ctlComplete) begin
          busy <= 1'b0;
        end
      end else begin
        halfCnt <= halfCnt + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register, target bit counter and wait bookkeeping
  always_ff @(posedge clk) begin
    if (rst) begin
      shift       <= spi_pkg::DATA_RESET;
      rxBit       <= 1'b0;
      bitCnt      <= 3'h0;
      pendingCopy <= 1'b0;
      discardNext <= 1'b0;
      frozenLast  <= 1'b0;
    end else begin
      frozenLast <= frozen;
      if (ctlStart) begin
        shift <= txData;
      end else if (ctlTick) begin
        if (!edgeCnt[0]) begin
          rxBit <= serIn;
        end else begin
          shift <= {shift[6:0], rxBit};
        end
      end
      if (tgtSelStart) begin
        bitCnt <= 3'h0;
        if (!txEmpty) begin
          shift <= txData;
        end
      end else if (tgtRise) begin
        rxBit <= serIn;
      end else if (tgtFall) begin
        shift  <= {shift[6:0], rxBit};
        bitCnt <= bitCnt + 3'h1;
      end
      if (!unitEnable || faultEvt) begin
        bitCnt <= 3'h0;
      end
      if (freezeEntry && !controllerRole && bitCnt != 3'h0) begin
        discardNext <= 1'b1;
      end
      if (tgtComplete) begin
        if (discardNext) begin
          discardNext <= 1'b0;
        end else if (frozen) begin
          pendingCopy <= 1'b1;
        end
      end
      if (freezeExit) begin
        pendingCopy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data and status flags
  logic copyNow, txLoad;
  assign copyNow = ctlComplete | (tgtComplete & ~discardNext & ~frozen) |
                   (freezeExit & pendingCopy);
  assign txLoad  = ctlStart | (tgtSelStart & ~txEmpty);

  always_ff @(posedge clk) begin
    if (rst) begin
      rxData    <= spi_pkg::DATA_RESET;
      txData    <= spi_pkg::DATA_RESET;
      txEmpty   <= 1'b1;
      doneFlag  <= 1'b0;
      doneArmed <= 1'b0;
    end else begin
      if (rdAcc && isOff(paddr, spi_pkg::STATUS_OFF) && doneFlag) begin
        doneArmed <= 1'b1;
      end
      if (accessPh && isOff(paddr, spi_pkg::DATA_OFF) && doneArmed) begin
        doneFlag  <= 1'b0;
        doneArmed <= 1'b0;
      end
      if (copyNow) begin
        rxData   <= ctlComplete ? {shift[6:0], rxBit} :
                    (freezeExit & pendingCopy) ? shift : {shift[6:0], rxBit};
        doneFlag <= 1'b1;
      end
      if (txLoad) begin
        txEmpty <= 1'b1;
      end
      if (wrAcc && isOff(paddr, spi_pkg::DATA_OFF)) begin
        txData  <= pwdata[7:0];
        txEmpty <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data, captured in the setup phase
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setupPh) begin
      case (paddr)
        spi_pkg::CTRL1_OFF:  prdata <= {29'h0000_0000, selectOutEn, controllerRole, unitEnable};
        spi_pkg::CTRL2_OFF:  prdata <= {28'h000_0000, faultDetectEn, haltInWait, sharedOe, singlePin};
        spi_pkg::BAUD_OFF:   prdata <= {25'h000_0000, baudPreselect, 1'b0, baudSelect};
        spi_pkg::STATUS_OFF: prdata <= {28'h000_0000, busy, faultFlag, txEmpty, doneFlag};
        spi_pkg::DATA_OFF:   prdata <= {24'h00_0000, rxData};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  always_comb begin
    pinOut      = '0;
    pinOe       = '0;
    pinOut.sclk = sclkReg;
    pinOut.mosi = shift[7];
    pinOut.miso = shift[7];
    pinOut.sel  = ~busy;
    if (unitEnable && controllerRole) begin
      pinOe.sclk = 1'b1;
      pinOe.mosi = singlePin ? sharedOe : 1'b1;
      pinOe.sel  = autoSelect;
    end else if (unitEnable && !faultFlag && !selSync[1]) begin
      pinOe.miso = singlePin ? sharedOe : 1'b1;
    end
  end

  assign irq = unitEnable & (faultFlag | doneFlag | txEmpty);

endmodule

// ---- verification/spi_target_model.sv ----
`timescale 1ns/10ps

module spi_target_model (
  // Serial side
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       selN,
  output logic            miso,
  // Bench side
  input  wire logic [7:0] txByte,
  output logic      [7:0] rxByte
);
  logic [7:0] shift;
  logic       held = 1'b0;

  // Released line shows the inverse of its last bit
  assign miso = selN ? ~held : shift[7];

  always @(negedge selN) shift = txByte;
  always @(posedge selN) held = shift[7];
  always @(posedge sclk) begin
    if (!selN) rxByte = {rxByte[6:0], mosi};
  end
  always @(negedge sclk) begin
    if (!selN) shift = {shift[6:0], 1'b0};
  end
endmodule

// ---- verification/spi_baud_fault_lowpower_checker.sv ----
`timescale 1ns/10ps

module spi_baud_fault_lowpower_checker (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Power, pins, request
  input wire logic               waitMode,
  input wire logic               stopMode,
  input wire spi_pkg::spi_pins_s pinIn,
  input wire spi_pkg::spi_pins_s pinOut,
  input wire spi_pkg::spi_pins_s pinOe,
  input wire logic               irq
);
  logic [7:0]  baud;
  logic [3:0]  ctrl2;
  logic        unitOn;
  logic [10:0] halfCnt;
  logic [10:0] halfLen;
  logic        frz;
  logic        hold;

  assign halfLen = 11'({1'b0, baud[6:4]} + 4'h1) << baud[2:0];
  assign hold    = stopMode || (waitMode && ctrl2[spi_pkg::HALT_IN_WAIT_BIT] && pinOe.sclk);

  // Shadow of the written configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      baud   <= 8'h00;
      ctrl2  <= 4'h0;
      unitOn <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == spi_pkg::BAUD_OFF) baud <= pwdata[7:0];
      if (paddr == spi_pkg::CTRL2_OFF) ctrl2 <= pwdata[3:0];
      if (paddr == spi_pkg::CTRL1_OFF) unitOn <= pwdata[spi_pkg::UNIT_ENABLE_BIT];
    end
  end

  // Cycles since the last serial clock edge or transfer start
  always_ff @(posedge clk) begin
    if (rst || $changed(pinOut.sclk) || $fell(pinOut.sel)) begin
      halfCnt <= 11'h001;
      frz     <= 1'b0;
    end else begin
      halfCnt <= halfCnt + 11'h001;
      frz     <= frz | waitMode | stopMode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_HALF_PERIOD: assert property ($changed(pinOut.sclk) && pinOe.sclk && !frz |-> halfCnt == halfLen)
    else $error("serial clock half period wrong");
  AST_SEL_LOW: assert property ($changed(pinOut.sclk) && pinOe.sel |-> !$past(pinOut.sel))
    else $error("select high during transfer");
  AST_IDLE_QUIET: assert property (pinOut.sel [*3] |-> $stable(pinOut.sclk))
    else $error("serial clock moves while idle");
  AST_AUTO_SEL: assert property (pinOe.sel |-> pinOe.sclk && ctrl2[spi_pkg::FAULT_DETECT_BIT])
    else $error("select driven outside controller mode");
  AST_FAULT_OFF: assert property (pinOe.sclk && !pinOe.sel && ctrl2[spi_pkg::FAULT_DETECT_BIT] && !pinIn.sel
      && !stopMode && !waitMode |-> ##[1:6] !pinOe.sclk && !pinOe.mosi)
    else $error("drivers still on after select fault");
  AST_NO_FAULT: assert property (pinOe.sclk && !ctrl2[spi_pkg::FAULT_DETECT_BIT] && !psel |=> pinOe.sclk)
    else $error("controller dropped without fault detection");
  AST_TARGET_PINS: assert property (pinOe.miso |-> !pinOe.sclk && !pinOe.sel && !pinOe.mosi)
    else $error("target drives a controller pin");
  AST_SHARED_IN: assert property (ctrl2[spi_pkg::SINGLE_PIN_BIT] && !ctrl2[spi_pkg::SHARED_OE_BIT] |->
      !pinOe.mosi && !pinOe.miso)
    else $error("shared pin driven while input");
  AST_DISABLED: assert property (!unitOn |-> !irq && pinOe == 4'h0)
    else $error("disabled unit drives pins or request");
  AST_FREEZE: assert property (hold && $past(hold) |-> $stable(pinOut.sclk) && $stable(pinOut.sel))
    else $error("transfer moved while frozen");

  cover property ($fell(pinOut.sel));
  cover property ($fell(pinOe.sclk) && unitOn);
  cover property (hold ##1 hold);
endmodule

bind spi_baud_fault_lowpower spi_baud_fault_lowpower_checker spi_baud_fault_lowpower_checker_i (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .waitMode(waitMode),
  .stopMode(stopMode), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));

// ---- verification/tb_spi_baud_fault_lowpower.sv ----
`timescale 1ns/10ps

module tb_spi_baud_fault_lowpower;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               waitMode = 1'b0;
  logic               stopMode = 1'b0;
  logic               tbSel = 1'b1;
  logic               tbSclk = 1'b0;
  logic               tbMosi = 1'b0;
  spi_pkg::spi_pins_s pinIn;
  spi_pkg::spi_pins_s pinOut;
  spi_pkg::spi_pins_s pinOe;
  logic               irq;
  logic               tgtMiso;
  logic [7:0]         tgtTx = 8'h00;
  logic [7:0]         tgtRx;
  logic [31:0]        lfsr = 32'h374c_422a;
  logic [65:0]        expQ[$];
  logic [65:0]        note;
  int                 n_fail = 0;
  int                 n_checks = 0;

  always #5 clk = ~clk;

  assign pinIn = {pinOe.sclk ? pinOut.sclk : tbSclk, pinOe.mosi ? pinOut.mosi : tbMosi,
                  pinOe.miso ? pinOut.miso : tgtMiso, pinOe.sel ? pinOut.sel : tbSel};

  spi_baud_fault_lowpower spi_baud_fault_lowpower_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .waitMode(waitMode), .stopMode(stopMode), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
  spi_target_model spi_target_model_i (.sclk(pinIn.sclk), .mosi(pinIn.mosi), .selN(pinIn.sel),
    .miso(tgtMiso), .txByte(tgtTx), .rxByte(tgtRx));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got, input logic [32:0] m);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp & m, got & m);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    if (pready !== 1'b1) begin
      n_fail++;
      finish_test();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input logic err);
    logic [31:0] r;
    expQ.push_back({1'b1, 24'hff_ffff, m, err, 24'h00_0000, e});
    apb(1'b0, a, 8'h00, r);
  endtask

  task automatic wait_done();
    logic [31:0] r;
    int n;
    r = 32'h0000_0000;
    for (n = 0; n < 6000 && !r[spi_pkg::DONE_BIT]; n++) apb(1'b0, spi_pkg::STATUS_OFF, 8'h00, r);
    if (r[spi_pkg::DONE_BIT] !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask

  // One controller byte each way; freeze 1 stops, 2 waits with halt
  task automatic xfer(input logic [7:0] b, input int freeze);
    logic [31:0] r;
    logic [10:0] h;
    h = 11'({1'b0, b[6:4]} + 4'h1) << b[2:0];
    r = rnd();
    tgtTx <= r[15:8];
    wr(spi_pkg::CTRL2_OFF, freeze == 2 ? 8'h0c : 8'h08);
    wr(spi_pkg::BAUD_OFF, b);
    wr(spi_pkg::DATA_OFF, r[7:0]);
    if (freeze > 0) begin
      repeat (13) @(posedge clk);
      stopMode <= (freeze == 1);
      waitMode <= (freeze == 2);
      repeat (40) @(posedge clk);
      stopMode <= 1'b0;
      waitMode <= 1'b0;
    end
    wait_done();
    rd(spi_pkg::DATA_OFF, r[15:8], h > 11'h003 ? 8'hff : 8'h00, 1'b0);
    chk("target rx", {25'h0, r[7:0]}, {25'h0, tgtRx}, 33'h0_0000_00ff);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      note = expQ.pop_front();
      chk("read", note[32:0], {pslverr, prdata}, note[65:33]);
    end
  end

  initial begin
    #1_000_000;
    n_fail++;
    finish_test();
  end

  initial begin
    logic [7:0] bauds [8];
    logic [31:0] r;
    logic [7:0]  got;
    bauds = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h41, 8'h07, 8'h77};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(spi_pkg::DATA_OFF, 8'h00, 8'hff, 1'b0);
    rd(8'h20, 8'h00, 8'hff, 1'b1);
    wr(spi_pkg::BAUD_OFF, 8'h41);
    rd(spi_pkg::BAUD_OFF, 8'h41, 8'h77, 1'b0);
    $display("reset and disabled access done");
    wr(spi_pkg::CTRL1_OFF, 8'h07);
    foreach (bauds[i]) xfer(bauds[i], 0);
    $display("divisor table done");
    xfer(8'h02, 1);
    xfer(8'h02, 2);
    $display("stop and wait done");
    wr(spi_pkg::CTRL2_OFF, 8'h0b);
    wr(spi_pkg::CTRL1_OFF, 8'h03);
    tbSel <= 1'b0;
    repeat (10) @(posedge clk);
    chk("irq", 33'h1, {32'h0, irq}, 33'h1);
    rd(spi_pkg::CTRL1_OFF, 8'h01, 8'h07, 1'b0);
    rd(spi_pkg::CTRL2_OFF, 8'h09, 8'h0f, 1'b0);
    tbSel <= 1'b1;
    repeat (4) @(posedge clk);
    rd(spi_pkg::STATUS_OFF, 8'h04, 8'h04, 1'b0);
    wr(spi_pkg::CTRL1_OFF, 8'h03);
    rd(spi_pkg::STATUS_OFF, 8'h00, 8'h04, 1'b0);
    $display("mode fault done");
    wr(spi_pkg::CTRL2_OFF, 8'h00);
    tbSel <= 1'b0;
    repeat (10) @(posedge clk);
    rd(spi_pkg::STATUS_OFF, 8'h00, 8'h04, 1'b0);
    rd(spi_pkg::CTRL1_OFF, 8'h03, 8'h07, 1'b0);
    tbSel <= 1'b1;
    $display("fault detection off done");
    // Target byte clocked by the bench while waiting with halt set
    wr(spi_pkg::CTRL1_OFF, 8'h01);
    wr(spi_pkg::CTRL2_OFF, 8'h04);
    r = rnd();
    wr(spi_pkg::DATA_OFF, r[7:0]);
    waitMode <= 1'b1;
    tbSel    <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      tbMosi <= r[8 + i];
      repeat (4) @(posedge clk);
      got[i] = pinIn.miso;
      tbSclk <= 1'b1;
      repeat (4) @(posedge clk);
      tbSclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    tbSel <= 1'b1;
    rd(spi_pkg::STATUS_OFF, 8'h00, 8'h01, 1'b0);
    waitMode <= 1'b0;
    repeat (4) @(posedge clk);
    rd(spi_pkg::DATA_OFF, r[15:8], 8'hff, 1'b0);
    chk("target miso", {25'h0, r[7:0]}, {25'h0, got}, 33'h0_0000_00ff);
    $display("target in wait done");
    finish_test();
  end
endmodule
